// ==== logic/sop_pkg.sv ====
`default_nettype none

package sop_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int PIN_N  = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_DIR  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PORT = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STAT = 4'hC;

  // field positions
  localparam int PIN_DAT_BIT    = 0;
  localparam int PIN_CLK_BIT    = 1;
  localparam int CTL_EN_BIT     = 0;
  localparam int CTL_MSTR_BIT   = 1;
  localparam int CTL_OD_BIT     = 2;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_SS_BIT    = 1;

  // per-pin bundle, bit 0 data pin, bit 1 clock pin
  typedef struct packed {
    logic clk;
    logic dat;
  } sop_pins_t;

  typedef struct packed {
    logic open_drain_select;
    logic master_active;
    logic serial_if_enable;
  } sop_ctl_t;

  // bundle that crosses from the link domain to the core domain
  typedef struct packed {
    logic      ss_n;
    sop_pins_t level;
    sop_pins_t drive;
    sop_pins_t drv_en;
  } sop_back_t;

  // reset values
  localparam sop_pins_t PINS_RST  = 2'h0;
  localparam sop_ctl_t  CTL_RST   = 3'h0;
  localparam logic      FAULT_RST = 1'h0;

  // synchroniser depth for pin and cross-domain inputs
  localparam int SYNC_STAGES = 3;

endpackage

`default_nettype wire

// ==== logic/sop_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser, output follows once stages two and three agree
module sop_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level
);
  import sop_pkg::*;

  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta   <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      meta   <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // each bit settles on its own
  always_ff @(posedge clk)
  begin
    if (!rstn)
      level <= '0;
    else
      for (int i = 0; i < W; i++)
        if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
  end

endmodule // sop_pin_sync

`default_nettype wire

// ==== logic/sop_pin_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module sop_pin_ctrl (
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  // register bus
  input  wire logic [sop_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [sop_pkg::DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [sop_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  // link side, serial core and pins
  input  wire logic                          link_clk,
  input  wire logic                          master_serial_out,
  input  wire logic                          master_clock_out,
  input  wire logic                          slave_select_n_level,
  input  wire logic                          data_out_pin_level,
  output logic                               data_out_pin_drive,
  output logic                               data_out_pin_oe,
  input  wire logic                          clock_pin_level,
  output logic                               clock_pin_drive,
  output logic                               clock_pin_oe,
  output logic                               slave_data_in,
  output logic                               slave_clock_in,
  output logic                               shift_clock
);
  import sop_pkg::*;

  function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus slave, one wait cycle per access

  logic                  ack;
  logic                  take;
  logic                  wr_lane0;
  logic                  direction_write_strobe;
  logic                  direction_read_strobe;
  logic                  port_write_strobe;
  logic                  port_read_strobe;
  logic                  ctrl_write_strobe;
  logic                  stat_write_strobe;
  logic [DATA_W-1:0]     next_readdata;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign take            = (avs_read | avs_write) & ack;
  assign wr_lane0        = take & avs_write & avs_byteenable[0];

  assign direction_write_strobe = wr_lane0 & sel(avs_address, OFF_DIR);
  assign port_write_strobe      = wr_lane0 & sel(avs_address, OFF_PORT);
  assign ctrl_write_strobe      = wr_lane0 & sel(avs_address, OFF_CTRL);
  assign stat_write_strobe      = wr_lane0 & sel(avs_address, OFF_STAT);
  assign direction_read_strobe  = avs_read & ~ack & sel(avs_address, OFF_DIR);
  assign port_read_strobe       = avs_read & ~ack & sel(avs_address, OFF_PORT);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  //////////////////////////////////////////////////////////////////////////////
  // core-domain state

  sop_pins_t port_direction_bits;
  sop_pins_t port_latch;
  sop_ctl_t  ctl;
  logic      mode_fault;
  logic      fault_cond;
  sop_back_t back;
  sop_pins_t port_read;
  sop_pins_t lvl_l;
  sop_pins_t drive_l;
  sop_pins_t drv_en_l;

  sop_pin_sync #(.W($bits(sop_back_t))) u_core_sync (
    .clk      (core_clk),
    .rstn     (rstn),
    .async_in ({slave_select_n_level, lvl_l, drive_l, drv_en_l}),
    .level    (back)
  );

  // master selected as slave by another party
  assign fault_cond = ctl.serial_if_enable & ctl.master_active & ~back.ss_n;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      port_direction_bits <= PINS_RST;
    else if (fault_cond)
      port_direction_bits <= PINS_RST;
    else if (direction_write_strobe)
      port_direction_bits <= sop_pins_t'(avs_writedata[PIN_N-1:0]);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      port_latch <= PINS_RST;
    else if (port_write_strobe)
      port_latch <= sop_pins_t'(avs_writedata[PIN_N-1:0]);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      ctl <= CTL_RST;
    else if (ctrl_write_strobe)
      ctl <= sop_ctl_t'(avs_writedata[2:0]);
  end

  // sticky fault, write one to clear, a new fault wins
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      mode_fault <= FAULT_RST;
    else if (fault_cond)
      mode_fault <= 1'b1;
    else if (stat_write_strobe && avs_writedata[STAT_FAULT_BIT])
      mode_fault <= 1'b0;
  end

  // driven pins read the output stage, undriven pins the buffered level
  always_comb
  begin
    port_read.dat = back.drv_en.dat ? back.drive.dat : back.level.dat;
    port_read.clk = back.drv_en.clk ? back.drive.clk : back.level.clk;
  end

  always_comb
  begin
    next_readdata = '0;
    if (direction_read_strobe)
      next_readdata[PIN_N-1:0] = port_direction_bits;
    else if (port_read_strobe)
      next_readdata[PIN_N-1:0] = port_read;
    else if (sel(avs_address, OFF_CTRL))
      next_readdata[2:0] = ctl;
    else if (sel(avs_address, OFF_STAT))
    begin
      next_readdata[STAT_FAULT_BIT] = mode_fault;
      next_readdata[STAT_SS_BIT]    = back.ss_n;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      avs_readdata <= '0;
    else if (avs_read && !ack)
      avs_readdata <= next_readdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // link-domain reset and configuration crossing

  logic      link_rst_meta;
  logic      link_rstn;
  sop_ctl_t  ctl_meta;
  sop_ctl_t  ctl_l;
  sop_pins_t dir_meta;
  sop_pins_t dir_l;
  sop_pins_t latch_meta;
  sop_pins_t latch_l;

  always_ff @(posedge link_clk)
  begin
    link_rst_meta <= rstn;
    link_rstn     <= link_rst_meta;
  end

  always_ff @(posedge link_clk)
  begin
    if (!link_rstn)
    begin
      ctl_meta   <= CTL_RST;
      ctl_l      <= CTL_RST;
      dir_meta   <= PINS_RST;
      dir_l      <= PINS_RST;
      latch_meta <= PINS_RST;
      latch_l    <= PINS_RST;
    end
    else
    begin
      ctl_meta   <= ctl;
      ctl_l      <= ctl_meta;
      dir_meta   <= port_direction_bits;
      dir_l      <= dir_meta;
      latch_meta <= port_latch;
      latch_l    <= latch_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin stage on the link clock

  logic      ss_n_l;
  logic      fault_l;
  sop_pins_t oe_l;
  sop_pins_t next_drive;
  sop_pins_t next_drv_en;
  logic      slave_mode;

  sop_pin_sync #(.W(3)) u_link_sync (
    .clk      (link_clk),
    .rstn     (link_rstn),
    .async_in ({slave_select_n_level, clock_pin_level, data_out_pin_level}),
    .level    ({ss_n_l, lvl_l})
  );

  // local fault sense so the drivers let go before the core clears the bits
  assign fault_l    = ctl_l.serial_if_enable & ctl_l.master_active & ~ss_n_l;
  assign slave_mode = ctl_l.serial_if_enable & ~ctl_l.master_active;

  always_comb
  begin
    // disabled or master: direction bit decides unless fault_l; slave: forced off
    next_drv_en.dat = dir_l.dat & ~slave_mode & ~fault_l;
    next_drv_en.clk = dir_l.clk & ~slave_mode & ~fault_l;
    next_drive.dat  = ctl_l.serial_if_enable ? master_serial_out : latch_l.dat;
    next_drive.clk  = ctl_l.serial_if_enable ? master_clock_out : latch_l.clk;
  end

  always_ff @(posedge link_clk)
  begin
    if (!link_rstn)
    begin
      drive_l  <= PINS_RST;
      drv_en_l <= PINS_RST;
      oe_l     <= PINS_RST;
    end
    else
    begin
      drive_l  <= next_drive;
      drv_en_l <= next_drv_en;
      // open drain: a one is left to the external pull-up
      oe_l     <= next_drv_en & ~({PIN_N{ctl_l.open_drain_select}} & next_drive);
    end
  end

  assign data_out_pin_drive = drive_l.dat;
  assign clock_pin_drive    = drive_l.clk;
  assign data_out_pin_oe    = oe_l.dat;
  assign clock_pin_oe       = oe_l.clk;

  assign slave_data_in  = lvl_l.dat;
  assign slave_clock_in = lvl_l.clk;
  assign shift_clock    = ctl_l.master_active ? master_clock_out : lvl_l.clk;

  //////////////////////////////////////////////////////////////////////////////
  // checks, core domain

  sequence dir_write_s;
    direction_write_strobe && !fault_cond;
  endsequence

  sequence bus_wait_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  dir_write_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
      dir_write_s |=> port_direction_bits == $past(avs_writedata[PIN_N-1:0]))
    else $error("direction bits not loaded by register write");

  dir_reset_a:
    assert property (@(posedge core_clk)
      !rstn |=> port_direction_bits == PINS_RST)
    else $error("direction bits not cleared by reset");

  fault_clear_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
      fault_cond && direction_write_strobe |=> port_direction_bits == PINS_RST)
    else $error("direction write beat the mode fault clear");

  fault_flag_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
      fault_cond |=> mode_fault ##0 port_direction_bits == PINS_RST)
    else $error("mode fault not flagged or direction not cleared");

  port_latch_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
      bus_wait_s ##1 port_write_strobe |=> port_latch == $past(avs_writedata[PIN_N-1:0]))
    else $error("port latch not loaded by register write");

  port_read_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
      port_read_strobe && !back.drv_en.dat |=> avs_readdata[PIN_DAT_BIT] == $past(back.level.dat))
    else $error("undriven pin read did not return the pin level");

  //////////////////////////////////////////////////////////////////////////////
  // checks, link domain

  slave_release_a:
    assert property (@(posedge link_clk) disable iff (!link_rstn)
      slave_mode |=> !data_out_pin_oe && !clock_pin_oe)
    else $error("pin driven while enabled as slave");

  data_source_a:
    assert property (@(posedge link_clk) disable iff (!link_rstn)
      ctl_l.serial_if_enable |=> data_out_pin_drive == $past(master_serial_out))
    else $error("data pin not sourced from master data");

  clock_source_a:
    assert property (@(posedge link_clk) disable iff (!link_rstn)
      !ctl_l.serial_if_enable |=> clock_pin_drive == $past(latch_l.clk))
    else $error("clock pin not sourced from port latch");

  open_drain_a:
    assert property (@(posedge link_clk) disable iff (!link_rstn)
      $past(ctl_l.open_drain_select) && data_out_pin_drive |-> !data_out_pin_oe)
    else $error("pin driven high in open-drain mode");

  master_dir_a:
    assert property (@(posedge link_clk) disable iff (!link_rstn)
      ctl_l.serial_if_enable && ctl_l.master_active && !fault_l && dir_l.clk
      && !ctl_l.open_drain_select |=> clock_pin_oe)
    else $error("master clock pin not driven with direction bit set");

endmodule // sop_pin_ctrl

`default_nettype wire

// ==== dv/sop_peer.sv ====
`timescale 1ns/1ps
`default_nettype none

// far-side devices on the shared data and clock lines, with pull-ups
module sop_peer (
  input  wire logic dat_oe,
  input  wire logic dat_drv,
  input  wire logic clk_oe,
  input  wire logic clk_drv,
  input  wire logic peer_oe,
  input  wire logic peer_dat,
  input  wire logic peer_clk,
  input  wire logic peer_sel,
  output logic      dat_lvl,
  output logic      clk_lvl,
  output logic      ss_n
);
  // two drivers at once is a conflict and shows as unknown
  assign dat_lvl = (dat_oe & peer_oe) ? 1'bx : dat_oe ? dat_drv : peer_oe ? peer_dat : 1'b1;
  assign clk_lvl = (clk_oe & peer_oe) ? 1'bx : clk_oe ? clk_drv : peer_oe ? peer_clk : 1'b1;
  assign ss_n    = ~peer_sel;
endmodule // sop_peer

`default_nettype wire

// ==== dv/spi_out_clk_pin_logic_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module spi_out_clk_pin_logic_test;
  import sop_pkg::*;

  typedef struct packed {
    logic [2:0] ctl;
    logic [1:0] dir;
    logic [1:0] lat;
    logic       mso;
    logic       mco;
    logic [1:0] oe;
    logic [1:0] drv;
    logic [1:0] prt;
    logic       sh;
  } sop_row_t;

  // ctl is {open_drain_select, master_active, serial_if_enable}
  localparam sop_row_t ROWS [8] = '{
    '{3'h0, 2'h3, 2'h2, 1'b0, 1'b0, 2'h3, 2'h2, 2'h2, 1'b1},
    '{3'h0, 2'h0, 2'h1, 1'b0, 1'b0, 2'h0, 2'h1, 2'h3, 1'b1},
    '{3'h3, 2'h3, 2'h0, 1'b1, 1'b0, 2'h3, 2'h1, 2'h1, 1'b0},
    '{3'h3, 2'h1, 2'h3, 1'b0, 1'b0, 2'h1, 2'h0, 2'h2, 1'b0},
    '{3'h1, 2'h3, 2'h3, 1'b0, 1'b0, 2'h0, 2'h0, 2'h3, 1'b1},
    '{3'h4, 2'h3, 2'h1, 1'b0, 1'b0, 2'h2, 2'h1, 2'h1, 1'b0},
    '{3'h7, 2'h3, 2'h0, 1'b1, 1'b1, 2'h0, 2'h3, 2'h3, 1'b1},
    '{3'h2, 2'h3, 2'h0, 1'b0, 1'b1, 2'h3, 2'h0, 2'h0, 1'b1}
  };

  logic              core_clk = 1'b0;
  logic              link_clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              mso = 1'b0;
  logic              mco = 1'b0;
  logic              peer_oe = 1'b0;
  logic              peer_dat = 1'b0;
  logic              peer_clk = 1'b0;
  logic              peer_sel = 1'b0;
  logic              ss_n;
  logic              dat_lvl;
  logic              clk_lvl;
  logic              dat_drv;
  logic              dat_oe;
  logic              clk_drv;
  logic              clk_oe;
  logic              sdi;
  logic              sci;
  logic              shc;
  logic [31:0]       q;
  logic [1:0]        lv;
  sop_row_t          r;
  int                err_count = 0;
  int                total_checks = 0;

  always #12.5 core_clk = ~core_clk;
  always #3 link_clk = ~link_clk;

  sop_pin_ctrl i_sop_pin_ctrl (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_clk(link_clk),
    .master_serial_out(mso), .master_clock_out(mco), .slave_select_n_level(ss_n),
    .data_out_pin_level(dat_lvl), .data_out_pin_drive(dat_drv), .data_out_pin_oe(dat_oe),
    .clock_pin_level(clk_lvl), .clock_pin_drive(clk_drv), .clock_pin_oe(clk_oe),
    .slave_data_in(sdi), .slave_clock_in(sci), .shift_clock(shc)
  );

  sop_peer i_sop_peer (
    .dat_oe(dat_oe), .dat_drv(dat_drv), .clk_oe(clk_oe), .clk_drv(clk_drv),
    .peer_oe(peer_oe), .peer_dat(peer_dat), .peer_clk(peer_clk), .peer_sel(peer_sel),
    .dat_lvl(dat_lvl), .clk_lvl(clk_lvl), .ss_n(ss_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until an edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd_q);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] rd_q);
    bus(1'b0, a, 32'h0, rd_q);
  endtask

  // lets config cross to the link side and pin levels come back
  task automatic settle();
    repeat (20) @(posedge core_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    // reset values, unmapped offset and a write with lane 0 off
    chk("oe_rst", {clk_oe, dat_oe}, 2'h0);
    rd(OFF_DIR, q);
    chk("dir_rst", q, 32'h0);
    rd(OFF_CTRL, q);
    chk("ctrl_rst", q, 32'h0);
    rd(OFF_PORT, q);
    chk("port_rst", q, 32'h3);
    rd(OFF_STAT, q);
    chk("stat_rst", q, 32'h2);
    wr(4'h1, 32'hFF);
    rd(4'h1, q);
    chk("unmapped", q, 32'h0);
    avs_byteenable <= 4'hE;
    wr(OFF_DIR, 32'h3);
    avs_byteenable <= 4'hF;
    rd(OFF_DIR, q);
    chk("dir_be", q, 32'h0);
    $display("test reset done");

    foreach (ROWS[i])
    begin
      r = ROWS[i];
      wr(OFF_CTRL, {29'h0, r.ctl});
      wr(OFF_DIR, {30'h0, r.dir});
      wr(OFF_PORT, {30'h0, r.lat});
      @(posedge link_clk);
      mso <= r.mso;
      mco <= r.mco;
      settle();
      lv[0] = r.oe[0] ? r.drv[0] : 1'b1;
      lv[1] = r.oe[1] ? r.drv[1] : 1'b1;
      rd(OFF_DIR, q);
      chk("dir", q, {30'h0, r.dir});
      chk("oe", {clk_oe, dat_oe}, r.oe);
      chk("drive", {clk_drv, dat_drv}, r.drv);
      rd(OFF_PORT, q);
      chk("port", q, {30'h0, r.prt});
      chk("sdi", sdi, lv[0]);
      chk("sci", sci, lv[1]);
      chk("shift", shc, r.sh);
    end
    $display("test rows done");

    // selected while slave: no fault
    wr(OFF_CTRL, 32'h1);
    peer_sel <= 1'b1;
    settle();
    rd(OFF_STAT, q);
    chk("stat_slave", q, 32'h0);
    // selected while master: fault clears direction and drops drivers
    wr(OFF_DIR, 32'h3);
    wr(OFF_CTRL, 32'h3);
    settle();
    rd(OFF_STAT, q);
    chk("stat_fault", q, 32'h1);
    rd(OFF_DIR, q);
    chk("dir_fault", q, 32'h0);
    chk("oe_fault", {clk_oe, dat_oe}, 2'h0);
    wr(OFF_DIR, 32'h3);
    rd(OFF_DIR, q);
    chk("dir_race", q, 32'h0);
    // other party drives both lines low, own clock high
    peer_oe <= 1'b1;
    @(posedge link_clk);
    mco <= 1'b1;
    settle();
    chk("sdi_peer", sdi, 1'b0);
    chk("sci_peer", sci, 1'b0);
    chk("shift_own", shc, 1'b1);
    rd(OFF_PORT, q);
    chk("port_peer", q, 32'h0);
    peer_oe <= 1'b0;
    peer_sel <= 1'b0;
    settle();
    rd(OFF_STAT, q);
    chk("stat_sticky", q, 32'h3);
    wr(OFF_STAT, 32'h1);
    rd(OFF_STAT, q);
    chk("stat_clear", q, 32'h2);
    $display("test fault done");

    // mid-run reset drops driven pins and clears the registers
    wr(OFF_DIR, 32'h3);
    wr(OFF_CTRL, 32'h4);
    settle();
    chk("oe_pre", {clk_oe, dat_oe}, 2'h3);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    settle();
    chk("oe_rst2", {clk_oe, dat_oe}, 2'h0);
    rd(OFF_DIR, q);
    chk("dir_rst2", q, 32'h0);
    rd(OFF_CTRL, q);
    chk("ctrl_rst2", q, 32'h0);
    $display("test reset again done");
    finish_test();
  end
endmodule // spi_out_clk_pin_logic_test

`default_nettype wire
